// ---- core/breakpoint_debug_unit.sv ----
`timescale 1ns/1ns
`include "bp_debug_defs.svh"

// Functional notes
// R1: Opcode CC raises exception 3 trap
// R2: Opcode CC skips the I/O privilege check
// R3: Step flag bit 8 tested at instruction end
// R4: Step trap follows the instruction after setting
// R5: Step trap return pointer is next instruction
// R6: Reset leaves every breakpoint disabled
// R7: Breakpoints are delivered as exception 1
// R8: Four 32-bit addresses compared to linear addresses
// R9: Comparison uses linear addresses, never translated
// R10: Length codes mask low address bits
// R11: Software uses length 00 for execution
// R12: Access type selects execute, write, read-write
// R13: Software never programs code 10
// R14: Execution breakpoints fault, data breakpoints trap
// R15: Overlapping data access raises exception 1 trap
// R16: Global or local enable arms a breakpoint
// R17: Hit flag set when condition occurs; the code sets hit flags only in a cycle where an armed breakpoint fires
// R18: Execution match uses first instruction byte
module breakpoint_debug_unit
#(
   parameter int NUM_BP = 4
)
(
   input  wire logic                      sys_clk,
   input  wire logic                      rst,
   input  wire logic                      wb_cyc,
   input  wire logic                      wb_stb,
   input  wire logic                      wb_we,
   input  wire logic [7:0]                wb_adr,
   input  wire logic [3:0]                wb_sel,
   input  wire logic [31:0]               wb_dat_w,
   output      logic [31:0]               wb_dat_r,
   output      logic                      wb_ack,
   input  wire bp_debug_pkg::exec_req_t   exec_req,
   input  wire bp_debug_pkg::data_acc_t   data_acc,
   input  wire bp_debug_pkg::retire_t     retire,
   input  wire logic                      task_switch,
   output      bp_debug_pkg::exc_t        exc,
   output      logic                      irq
);

   generate
      if (NUM_BP != 4)
      begin : g_bad_count
         $error("NUM_BP must be 4 to match the control layout");
      end
   endgenerate

   logic [31:0]           bp_addr_r [NUM_BP];
   logic [31:0]           ctrl_r;
   logic [`BPD_ST_WIDTH-1:0] status_r;
   logic [`BPD_ST_WIDTH-1:0] mask_r;
   logic                  dtrap_pend_r;
   logic                  ack_r;
   logic [31:0]           dat_r;
   logic                  irq_r;
   bp_debug_pkg::exc_t    exc_r;

   logic [NUM_BP-1:0]     armed;
   logic [NUM_BP-1:0]     exec_cond;
   logic [NUM_BP-1:0]     data_cond;
   logic [NUM_BP-1:0]     exec_hit;
   logic [NUM_BP-1:0]     data_hit;
   logic [NUM_BP-1:0]     hit_set;
   logic                  exec_fault;
   logic                  data_trap;
   logic                  step_due;
   logic                  int3_op;
   logic                  int_n_gp;
   logic                  wb_req;
   logic                  wb_wr;
   logic [31:0]           wmask;
   logic [`BPD_ST_WIDTH-1:0] st_set;

   // Per-breakpoint comparators on linear addresses only
   genvar gi;
   generate
      for (gi = 0; gi < NUM_BP; gi++)
      begin : g_bp
         logic [31:0] cmp_addr;
         assign cmp_addr = exec_req.valid ? exec_req.lin_addr : data_acc.lin_addr; // [R9]
         bp_comparator u_cmp
         (
            .bp_addr     (bp_addr_r[gi]),
            .bp_len      (ctrl_r[`BPD_LEN_POS + gi*`BPD_TYPE_STRIDE +: 2]),
            .bp_rw       (ctrl_r[`BPD_RW_POS + gi*`BPD_TYPE_STRIDE +: 2]),
            .acc_addr    (cmp_addr),
            .acc_size_m1 (exec_req.valid ? 2'h0 : data_acc.size_m1),
            .acc_write   (data_acc.write),
            .exec_cond   (exec_cond[gi]),
            .data_cond   (data_cond[gi])
         );                                                                // [R8]
         assign armed[gi] = ctrl_r[gi*`BPD_EN_STRIDE + `BPD_LOC_EN_POS]
                          | ctrl_r[gi*`BPD_EN_STRIDE + `BPD_GLB_EN_POS];   // [R16]
      end
   endgenerate

   assign exec_hit   = exec_req.valid ? exec_cond : '0;
   assign data_hit   = (data_acc.valid && !exec_req.valid) ? data_cond : '0;
   assign exec_fault = |(exec_hit & armed);                                // [R14] [R16]
   assign data_trap  = |(data_hit & armed);                                // [R15]

   // All matching conditions recorded once any armed one fires
   always_comb
   begin
      hit_set = '0;
      if (exec_fault)
         hit_set = exec_hit;                                               // [R17]
      else if (data_trap)
         hit_set = data_hit;                                               // [R17]
   end

   step_tracker u_step
   (
      .sys_clk      (sys_clk),
      .rst          (rst),
      .retire_valid (retire.valid),
      .retire_flags (retire.flags),
      .step_due     (step_due)
   );

   assign int3_op  = retire.valid && (retire.opcode == `BPD_OPC_INT3);     // [R1]
   assign int_n_gp = retire.valid && retire.is_int_n && !int3_op
                     && (retire.prot_mode || retire.v86_mode)
                     && (retire.cpl > retire.io_privilege_level);                        // [R2]

   // Register bus decode
   assign wb_req = wb_cyc && wb_stb && !ack_r;
   assign wb_wr  = wb_req && wb_we;
   assign wmask  = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         ack_r <= 1'b0;
      else
         ack_r <= wb_req;
   end

   // Breakpoint address registers
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < NUM_BP; i++)
            bp_addr_r[i] <= `BPD_RST_ADDR;
      end
      else if (wb_wr)
      begin
         for (int i = 0; i < NUM_BP; i++)
            if (wb_adr == (`BPD_OFS_ADDR0 + 8'(4*i)))
               bp_addr_r[i] <= (bp_addr_r[i] & ~wmask) | (wb_dat_w & wmask);
      end
   end

   // Control register; task switch drops local enables
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         ctrl_r <= `BPD_RST_CTRL;                                          // [R6]
      else if (wb_wr && wb_adr == `BPD_OFS_CTRL)
         ctrl_r <= (ctrl_r & ~wmask) | (wb_dat_w & wmask);                 // [R13]
      else if (task_switch)
      begin
         for (int i = 0; i < NUM_BP; i++)
            ctrl_r[i*`BPD_EN_STRIDE + `BPD_LOC_EN_POS] <= 1'b0;
      end
   end

   assign st_set = {int3_op, step_due, hit_set};

   // Sticky status, write one to clear, set wins
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         status_r <= `BPD_RST_STATUS;
      else if (wb_wr && wb_adr == `BPD_OFS_STATUS && wb_sel[0])
         status_r <= (status_r & ~wb_dat_w[`BPD_ST_WIDTH-1:0]) | st_set;
      else
         status_r <= status_r | st_set;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         mask_r <= `BPD_RST_MASK;
      else if (wb_wr && wb_adr == `BPD_OFS_MASK && wb_sel[0])
         mask_r <= wb_dat_w[`BPD_ST_WIDTH-1:0];
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         irq_r <= 1'b0;
      else
         irq_r <= |(status_r & mask_r);
   end

   // Read data, unmapped reads as zero
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         dat_r <= 32'h0000_0000;
      else if (wb_req && !wb_we)
      begin
         if (wb_adr == `BPD_OFS_ADDR0)
            dat_r <= bp_addr_r[0];
         else if (wb_adr == `BPD_OFS_ADDR1)
            dat_r <= bp_addr_r[1];
         else if (wb_adr == `BPD_OFS_ADDR2)
            dat_r <= bp_addr_r[2];
         else if (wb_adr == `BPD_OFS_ADDR3)
            dat_r <= bp_addr_r[3];
         else if (wb_adr == `BPD_OFS_CTRL)
            dat_r <= ctrl_r;
         else if (wb_adr == `BPD_OFS_STATUS)
            dat_r <= {26'h000_0000, status_r};
         else if (wb_adr == `BPD_OFS_MASK)
            dat_r <= {26'h000_0000, mask_r};
         else
            dat_r <= 32'h0000_0000;
      end
   end

   // Data breakpoint waits for its instruction to retire
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         dtrap_pend_r <= 1'b0;
      else if (retire.valid)
         dtrap_pend_r <= 1'b0;
      else if (data_trap)
         dtrap_pend_r <= 1'b1;                                             // [R14]
   end

   // Exception request to the exception logic
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         exc_r <= '0;
      end
      else if (exec_fault)
      begin
         exc_r.valid  <= 1'b1;
         exc_r.vector <= `BPD_VEC_DEBUG;                                   // [R7]
         exc_r.fault  <= 1'b1;                                             // [R14]
         exc_r.ret_ip <= exec_req.lin_addr;
      end
      else if (retire.valid && (dtrap_pend_r || step_due))
      begin
         exc_r.valid  <= 1'b1;
         exc_r.vector <= `BPD_VEC_DEBUG;                                   // [R3] [R7]
         exc_r.fault  <= 1'b0;
         exc_r.ret_ip <= retire.next_ip;                                   // [R5]
      end
      else if (int3_op)
      begin
         exc_r.valid  <= 1'b1;
         exc_r.vector <= `BPD_VEC_INT3;                                    // [R1]
         exc_r.fault  <= 1'b0;
         exc_r.ret_ip <= retire.next_ip;
      end
      else if (int_n_gp)
      begin
         exc_r.valid  <= 1'b1;
         exc_r.vector <= `BPD_VEC_GPF;
         exc_r.fault  <= 1'b1;
         exc_r.ret_ip <= retire.next_ip;
      end
      else
      begin
         exc_r.valid  <= 1'b0;
      end
   end

   assign exc      = exc_r;
   assign irq      = irq_r;
   assign wb_ack   = ack_r;
   assign wb_dat_r = dat_r;

   // Checker state, kept apart from the trap logic it watches
   logic                  step_seen_r;
   logic                  data_owed_r;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         step_seen_r <= 1'b0;
      else if (retire.valid)
         step_seen_r <= retire.flags[`BPD_STEP_FLAG_POS];
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         data_owed_r <= 1'b0;
      else if (retire.valid)
         data_owed_r <= 1'b0;
      else if (data_acc.valid && !exec_req.valid && |(data_cond & armed))
         data_owed_r <= 1'b1;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   reset_disabled_a: assert property (@(posedge sys_clk) disable iff (1'b0)
                                      rst |=> (ctrl_r == `BPD_RST_CTRL) && !exc.valid && !irq) // [R6]
      else $error("breakpoints not disabled after reset");

   int3_vector_a: assert property (int3_op && !exec_fault && !dtrap_pend_r && !step_due
                                   |=> exc.valid && exc.vector == 8'h03 && !exc.fault) // [R1]
      else $error("breakpoint opcode did not give vector 3 trap");

   int3_no_gp_a: assert property (int3_op |=> !(exc.valid && exc.vector == 8'h0D)) // [R2]
      else $error("breakpoint opcode took privilege fault");

   step_trap_a: assert property (retire.valid && step_seen_r && !exec_fault
                                 |=> exc.valid && exc.vector == `BPD_VEC_DEBUG && !exc.fault) // [R4]
      else $error("single step trap missing");

   step_ret_a: assert property (step_due && !exec_fault |=> exc.ret_ip == $past(retire.next_ip)) // [R5]
      else $error("single step return pointer wrong");

   exec_fault_a: assert property (exec_fault |=> exc.valid && exc.fault && exc.vector == 8'h01
                                  && exc.ret_ip == $past(exec_req.lin_addr)) // [R14]
      else $error("execution breakpoint fault wrong");

   disarmed_quiet_a: assert property (exec_req.valid && armed == '0 |=> !(exc.valid && exc.fault
                                      && exc.vector == 8'h01)) // [R16]
      else $error("disarmed breakpoint raised fault");

   data_trap_a: assert property (retire.valid && data_owed_r && !exec_fault
                                 |=> exc.valid && exc.vector == `BPD_VEC_DEBUG && !exc.fault
                                 && exc.ret_ip == $past(retire.next_ip)) // [R15]
      else $error("data breakpoint trap missing");

   hit_flag_a: assert property (exec_fault |=> (status_r[3:0] & $past(exec_hit)) == $past(exec_hit)) // [R17]
      else $error("hit flag not set");

   irq_level_a: assert property (##1 irq == $past(|(status_r & mask_r)))
      else $error("interrupt level mismatch");

endmodule // breakpoint_debug_unit

// ---- inc/bp_debug_defs.svh ----
`ifndef BP_DEBUG_DEFS_SVH
`define BP_DEBUG_DEFS_SVH

// Register byte offsets
`define BPD_OFS_ADDR0      8'h00
`define BPD_OFS_ADDR1      8'h04
`define BPD_OFS_ADDR2      8'h08
`define BPD_OFS_ADDR3      8'h0C
`define BPD_OFS_CTRL       8'h10
`define BPD_OFS_STATUS     8'h14
`define BPD_OFS_MASK       8'h18

// Reset values
`define BPD_RST_ADDR       32'h0000_0000
`define BPD_RST_CTRL       32'h0000_0000
`define BPD_RST_STATUS     6'h00
`define BPD_RST_MASK       6'h00

// Control field positions (per breakpoint i)
`define BPD_LOC_EN_POS     0
`define BPD_GLB_EN_POS     1
`define BPD_EN_STRIDE      2
`define BPD_RW_POS         16
`define BPD_LEN_POS        18
`define BPD_TYPE_STRIDE    4

// Status / mask field positions
`define BPD_ST_HIT_POS     0
`define BPD_ST_STEP_POS    4
`define BPD_ST_INT3_POS    5
`define BPD_ST_WIDTH       6

// Flags word
`define BPD_STEP_FLAG_POS  8

// Codes
`define BPD_LEN_BYTE       2'h0
`define BPD_LEN_WORD       2'h1
`define BPD_LEN_DWORD      2'h3
`define BPD_RW_EXEC        2'h0
`define BPD_RW_WRITE       2'h1
`define BPD_RW_RDWR        2'h3
`define BPD_OPC_INT3       8'hCC
`define BPD_VEC_DEBUG      8'h01
`define BPD_VEC_INT3       8'h03
`define BPD_VEC_GPF        8'h0D

`endif

// ---- inc/bp_debug_pkg.sv ----
package bp_debug_pkg;

   typedef struct packed {
      logic        valid;
      logic [31:0] lin_addr;
   } exec_req_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] lin_addr;
      logic [1:0]  size_m1;
      logic        write;
   } data_acc_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] flags;
      logic [31:0] next_ip;
      logic [7:0]  opcode;
      logic        is_int_n;
      logic [7:0]  int_vector;
      logic        prot_mode;
      logic        v86_mode;
      logic [1:0]  cpl;
      logic [1:0]  io_privilege_level;
   } retire_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  vector;
      logic        fault;
      logic [31:0] ret_ip;
   } exc_t;

endpackage

// ---- core/bp_comparator.sv ----
`timescale 1ns/1ns
`include "bp_debug_defs.svh"

module bp_comparator
(
   input  wire logic [31:0] bp_addr,
   input  wire logic [1:0]  bp_len,
   input  wire logic [1:0]  bp_rw,
   input  wire logic [31:0] acc_addr,
   input  wire logic [1:0]  acc_size_m1,
   input  wire logic        acc_write,
   output      logic        exec_cond,
   output      logic        data_cond
);

   logic [31:0] len_mask;
   logic [31:0] fld_lo;
   logic [32:0] fld_hi;
   logic [32:0] acc_hi;

   // Aligned breakpoint field
   always_comb
   begin
      if (bp_len == `BPD_LEN_DWORD)
         len_mask = 32'h0000_0003;
      else if (bp_len == `BPD_LEN_WORD)
         len_mask = 32'h0000_0001;
      else
         len_mask = 32'h0000_0000;
   end

   assign fld_lo = bp_addr & ~len_mask;                                    // [R10]
   assign fld_hi = {1'b0, fld_lo | len_mask};
   assign acc_hi = {1'b0, acc_addr} + {31'h0000_0000, acc_size_m1};

   // First byte of the instruction against the field
   assign exec_cond = (bp_rw == `BPD_RW_EXEC) && ((acc_addr & ~len_mask) == fld_lo); // [R18]

   // Whole or partial overlap of the access with the field
   assign data_cond = ((bp_rw == `BPD_RW_RDWR) || (bp_rw == `BPD_RW_WRITE && acc_write))
                      && ({1'b0, acc_addr} <= fld_hi) && (acc_hi >= {1'b0, fld_lo}); // [R12] [R15]

endmodule // bp_comparator

// ---- core/step_tracker.sv ----
`timescale 1ns/1ns
`include "bp_debug_defs.svh"

module step_tracker
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        retire_valid,
   input  wire logic [31:0] retire_flags,
   output      logic        step_due
);

   logic step_prev_r;

   // Step flag as it stood before the retiring instruction ran
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         step_prev_r <= 1'b0;
      else if (retire_valid)
         step_prev_r <= retire_flags[`BPD_STEP_FLAG_POS];                  // [R3]
   end

   // The instruction that sets the flag is not itself trapped
   assign step_due = retire_valid && step_prev_r;                          // [R4]

endmodule // step_tracker

// ---- verification/exec_unit_model.sv ----
`timescale 1ns/1ns

module exec_unit_model
(
   input  wire logic                    sys_clk,
   output      bp_debug_pkg::exec_req_t exec_req,
   output      bp_debug_pkg::data_acc_t data_acc,
   output      bp_debug_pkg::retire_t   retire,
   output      logic                    task_switch
);
   initial
   begin
      exec_req    = '0;
      data_acc    = '0;
      retire      = '0;
      task_switch = 1'b0;
   end

   // First byte of the instruction, prefixes included
   task do_exec(input logic [31:0] a);
      @(posedge sys_clk);
      exec_req <= '{1'b1, a};
      @(posedge sys_clk);
      exec_req <= '{1'b0, ~a};
   endtask

   task do_data(input logic [31:0] a, input logic [1:0] sz, input logic wr);
      @(posedge sys_clk);
      data_acc <= '{1'b1, a, sz, wr};
      @(posedge sys_clk);
      data_acc <= '{1'b0, ~a, ~sz, ~wr};
   endtask

   task do_retire(input bp_debug_pkg::retire_t r);
      bp_debug_pkg::retire_t z;
      z = ~r;
      z.valid = 1'b0;
      @(posedge sys_clk);
      retire <= r;
      @(posedge sys_clk);
      retire <= z;
   endtask

   task do_switch;
      @(posedge sys_clk);
      task_switch <= 1'b1;
      @(posedge sys_clk);
      task_switch <= 1'b0;
   endtask
endmodule // exec_unit_model

// ---- verification/breakpoint_debug_unit_tb.sv ----
`timescale 1ns/1ns

module breakpoint_debug_unit_tb;
   logic                    sys_clk = 1'b0;
   logic                    rst = 1'b1;
   logic                    wb_cyc = 1'b0;
   logic                    wb_stb = 1'b0;
   logic                    wb_we = 1'b0;
   logic [7:0]              wb_adr = 8'h00;
   logic [3:0]              wb_sel = 4'h0;
   logic [31:0]             wb_dat_w = 32'h0000_0000;
   logic [31:0]             wb_dat_r;
   logic                    wb_ack;
   bp_debug_pkg::exec_req_t exec_req;
   bp_debug_pkg::data_acc_t data_acc;
   bp_debug_pkg::retire_t   retire;
   logic                    task_switch;
   bp_debug_pkg::exc_t      exc;
   bp_debug_pkg::exc_t      exc_last = '0;
   logic                    irq;
   int                      err_count = 0;
   int                      samples_checked = 0;
   int                      exc_cnt = 0;
   int                      exp_exc = 0;

   always #10 sys_clk = ~sys_clk;

   always @(posedge sys_clk)
   begin
      if (exc.valid === 1'b1)
      begin
         exc_cnt++;
         exc_last = exc;
      end
   end

   breakpoint_debug_unit #(.NUM_BP(4)) dut
   (
      .sys_clk(sys_clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
      .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
      .wb_ack(wb_ack), .exec_req(exec_req), .data_acc(data_acc), .retire(retire),
      .task_switch(task_switch), .exc(exc), .irq(irq)
   );

   exec_unit_model model
   (
      .sys_clk(sys_clk), .exec_req(exec_req), .data_acc(data_acc), .retire(retire),
      .task_switch(task_switch)
   );

   task results;
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge sys_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_sel <= 4'hF;
      wb_dat_w <= d;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (wb_ack !== 1'b1 && n < 20);
      q = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (n >= 20)
      begin
         err_count++;
         $display("[FAIL] %0t bus answer missing", $time);
         results();
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 32'h0000_0000, q);
      chk(q, exp, "register read");
   endtask

   task exc_chk(input int n, input logic [7:0] vec, input logic flt);
      repeat (3) @(posedge sys_clk);
      exp_exc += n;
      chk(32'(exc_cnt), 32'(exp_exc), "exception count");
      if (n > 0)
      begin
         chk({24'h0000_00, exc_last.vector}, {24'h0000_00, vec}, "vector");
         chk({31'h0000_0000, exc_last.fault}, {31'h0000_0000, flt}, "fault kind");
      end
   endtask

   task ret(input logic [31:0] flags, input logic [31:0] ip, input logic [7:0] opc, input logic isn);
      bp_debug_pkg::retire_t r;
      r = '{1'b1, flags, ip, opc, isn, 8'h03, 1'b1, 1'b0, 2'h3, 2'h0};
      model.do_retire(r);
   endtask

   task t_reset;
      rd(8'h10, 32'h0000_0000);
      rd(8'h1C, 32'h0000_0000);
      model.do_exec(32'h0000_0000);
      exc_chk(0, 8'h00, 1'b0);
   endtask

   task t_exec;
      wr(8'h00, 32'h0000_1000);
      wr(8'h18, 32'h0000_0001);
      wr(8'h10, 32'h0000_0002);
      model.do_exec(32'h0000_0FFF);
      exc_chk(0, 8'h00, 1'b0);
      model.do_exec(32'h0000_1000);
      exc_chk(1, 8'h01, 1'b1);
      chk(exc_last.ret_ip, 32'h0000_1000, "fault pointer");
      rd(8'h14, 32'h0000_0001);
      chk({31'h0000_0000, irq}, 32'h0000_0001, "irq raised");
      wr(8'h14, 32'h0000_0001);
      repeat (2) @(posedge sys_clk);
      chk({31'h0000_0000, irq}, 32'h0000_0000, "irq cleared");
   endtask

   task t_data;
      wr(8'h04, 32'h0000_0105);
      wr(8'h10, 32'h00D0_000A);
      model.do_data(32'h0000_0104, 2'h3, 1'b0);
      ret(32'h0000_0000, 32'h0000_0100, 8'h90, 1'b0);
      exc_chk(0, 8'h00, 1'b0);
      model.do_data(32'h0000_0108, 2'h0, 1'b1);
      ret(32'h0000_0000, 32'h0000_0100, 8'h90, 1'b0);
      exc_chk(0, 8'h00, 1'b0);
      model.do_data(32'h0000_0103, 2'h1, 1'b1);
      ret(32'h0000_0000, 32'h0000_0200, 8'h90, 1'b0);
      exc_chk(1, 8'h01, 1'b0);
      chk(exc_last.ret_ip, 32'h0000_0200, "trap pointer");
      rd(8'h14, 32'h0000_0002);
   endtask

   task t_step;
      ret(32'h0000_0100, 32'h0000_0300, 8'h90, 1'b0);
      exc_chk(0, 8'h00, 1'b0);
      ret(32'h0000_0000, 32'h0000_0304, 8'h90, 1'b0);
      exc_chk(1, 8'h01, 1'b0);
      chk(exc_last.ret_ip, 32'h0000_0304, "step pointer");
   endtask

   task t_opcode;
      ret(32'h0000_0000, 32'h0000_0400, 8'hCC, 1'b0);
      exc_chk(1, 8'h03, 1'b0);
      ret(32'h0000_0000, 32'h0000_0402, 8'hCD, 1'b1);
      exc_chk(1, 8'h0D, 1'b1);
      model.do_retire('{1'b1, 32'h0000_0000, 32'h0000_0404, 8'hCD, 1'b1, 8'h21, 1'b0, 1'b1, 2'h3, 2'h3});
      exc_chk(0, 8'h00, 1'b0);
   endtask

   task t_local;
      wr(8'h08, 32'h0000_2000);
      wr(8'h10, 32'h0000_0012);
      model.do_exec(32'h0000_2000);
      exc_chk(1, 8'h01, 1'b1);
      model.do_switch();
      model.do_exec(32'h0000_2000);
      exc_chk(0, 8'h00, 1'b0);
      rd(8'h10, 32'h0000_0002);
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rd(8'h10, 32'h0000_0000);
      model.do_exec(32'h0000_0000);
      exc_chk(0, 8'h00, 1'b0);
   endtask

   initial
   begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_exec();
      t_data();
      t_step();
      t_opcode();
      t_local();
      results();
   end
endmodule // breakpoint_debug_unit_tb
